// *** rtl/msp_top.sv ***
// message interrupt mask, pending and send logic
// Operation
// - a request for a masked vector sends no message to the host.
// - a masked request sets that function and vector's pending bit instead.
// - a pending vector is sent once its mask bit is clear.
// - a pending bit delivered on unmasking reads back as zero.
// - a pending bit cleared by the host before unmasking yields no message.
// - a masked request is still acknowledged, with result code 01.
// - each function and vector has its own mask bit, written via a selected function.
// - pending bits of the selected function are readable, set bits read as one.
// - legacy interrupt disable sits at bit 10 of the command register.
// - message enable sits at bit 16 of the dword at 0x050 and gates all messages.
// - programmed address and data form each message.
// - vectors at or above the enabled count are not usable.
// - with messages disabled or the capability absent a request is dropped with code 2.
// - an unmasked enabled request gets code 0 and a memory write with address and data.
`timescale 1ns/1ps
`default_nettype none
module msp_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // capability strap
  input wire logic msi_cap_present,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // application request
  input wire logic app_msi_req,
  input wire logic [1:0] app_msi_func,
  input wire logic [4:0] app_msi_num,
  output logic app_msi_ack,
  output logic [1:0] app_msi_status,
  // memory write toward host
  input wire logic tlp_ready,
  output logic tlp_valid,
  output logic [31:0] tlp_addr,
  output logic [31:0] tlp_data
);
  // ==================================================
  // state
  typedef struct packed {
    logic int_dis;
    logic msi_en;
    logic [2:0] mme;
    logic [31:0] addr;
    logic [15:0] data;
    logic [1:0] fsel;
    logic [msp_pkg::NUM_BITS-1:0] mask;
    logic [msp_pkg::NUM_BITS-1:0] pend;
    logic ack;
    logic [1:0] status;
    logic tlp_valid;
    logic [31:0] tlp_addr;
    logic [31:0] tlp_data;
    logic [31:0] rdata;
    logic rd_valid;
  } msp_state_s;

  msp_state_s st_ff;
  msp_state_s nxt_st;
  logic pick_found;
  logic [msp_pkg::IDX_W-1:0] pick_idx;
  logic [msp_pkg::IDX_W-1:0] req_idx;
  logic take;
  logic tlp_free;
  logic vec_ok;
  logic [4:0] vmask;
  logic [6:0] fbase;

  assign req_idx = {app_msi_func, app_msi_num};
  assign fbase = {st_ff.fsel, 5'h00};
  assign vmask = 5'((6'h01 << st_ff.mme) - 6'h01);
  assign vec_ok = (app_msi_num & ~vmask) == 5'h00;
  assign tlp_free = !st_ff.tlp_valid || tlp_ready;
  assign take = app_msi_req && !st_ff.ack;

  // ==================================================
  // releasable vectors
  msp_pick u_pick (
    .cand(st_ff.pend & ~st_ff.mask),
    .found(pick_found),
    .idx(pick_idx)
  );

  function automatic logic [31:0] msg_data(input logic [15:0] d, input logic [4:0] v,
                                           input logic [4:0] m);
    msg_data = {16'h0000, d[15:5], (d[4:0] & ~m) | (v & m)};
  endfunction : msg_data

  // ==================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.rd_valid = 1'b0;
    if (st_ff.tlp_valid && tlp_ready) begin
      nxt_st.tlp_valid = 1'b0;
    end
    // configuration writes
    if (cfg_wr) begin
      unique case (cfg_addr)
        msp_pkg::OFF_CMD: nxt_st.int_dis = cfg_wdata[msp_pkg::CMD_INTDIS_BIT];
        msp_pkg::OFF_CTRL: begin
          nxt_st.msi_en = cfg_wdata[msp_pkg::CTRL_EN_BIT];
          nxt_st.mme = (cfg_wdata[msp_pkg::CTRL_MME_LSB +: 3] > msp_pkg::MME_MAX) ?
                       msp_pkg::MME_MAX : cfg_wdata[msp_pkg::CTRL_MME_LSB +: 3];
        end
        msp_pkg::OFF_ADDR: nxt_st.addr = {cfg_wdata[31:2], 2'b00};
        msp_pkg::OFF_DATA: nxt_st.data = cfg_wdata[15:0];
        msp_pkg::OFF_MASK: nxt_st.mask[fbase +: 32] = cfg_wdata;
        msp_pkg::OFF_PEND:
          nxt_st.pend[fbase +: 32] = st_ff.pend[fbase +: 32] & ~cfg_wdata;
        msp_pkg::OFF_FSEL: nxt_st.fsel = cfg_wdata[1:0];
        default: ;
      endcase
    end
    // configuration reads
    if (cfg_rd) begin
      nxt_st.rd_valid = 1'b1;
      unique case (cfg_addr)
        msp_pkg::OFF_CMD: nxt_st.rdata = 32'(st_ff.int_dis) << msp_pkg::CMD_INTDIS_BIT;
        msp_pkg::OFF_CTRL: begin
          nxt_st.rdata = {24'h000000, msp_pkg::CAP_ID};
          nxt_st.rdata[msp_pkg::CTRL_EN_BIT] = st_ff.msi_en;
          nxt_st.rdata[msp_pkg::CTRL_MMC_LSB +: 3] = msp_pkg::MMC_VAL;
          nxt_st.rdata[msp_pkg::CTRL_MME_LSB +: 3] = st_ff.mme;
          nxt_st.rdata[msp_pkg::CTRL_PVM_BIT] = 1'b1;
        end
        msp_pkg::OFF_ADDR: nxt_st.rdata = st_ff.addr;
        msp_pkg::OFF_DATA: nxt_st.rdata = {16'h0000, st_ff.data};
        msp_pkg::OFF_MASK: nxt_st.rdata = st_ff.mask[fbase +: 32];
        msp_pkg::OFF_PEND: nxt_st.rdata = st_ff.pend[fbase +: 32];
        msp_pkg::OFF_FSEL: nxt_st.rdata = {30'h00000000, st_ff.fsel};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
    // application requests, then release of pending vectors
    if (take) begin
      if (!msi_cap_present || !st_ff.msi_en || !vec_ok) begin
        nxt_st.ack = 1'b1;
        nxt_st.status = msp_pkg::ST_DROP;
      end else if (st_ff.mask[req_idx]) begin
        nxt_st.ack = 1'b1;
        nxt_st.status = msp_pkg::ST_HELD;
        nxt_st.pend[req_idx] = 1'b1;
      end else if (tlp_free) begin
        nxt_st.ack = 1'b1;
        nxt_st.status = msp_pkg::ST_SENT;
        nxt_st.tlp_valid = 1'b1;
        nxt_st.tlp_addr = st_ff.addr;
        nxt_st.tlp_data = msg_data(st_ff.data, app_msi_num, vmask);
      end
    end else if (msi_cap_present && st_ff.msi_en && pick_found && tlp_free) begin
      nxt_st.tlp_valid = 1'b1;
      nxt_st.tlp_addr = st_ff.addr;
      nxt_st.tlp_data = msg_data(st_ff.data, pick_idx[4:0], vmask);
      nxt_st.pend[pick_idx] = 1'b0;
    end
  end

  // ==================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg_rdata = st_ff.rdata;
  assign cfg_rd_valid = st_ff.rd_valid;
  assign app_msi_ack = st_ff.ack;
  assign app_msi_status = st_ff.status;
  assign tlp_valid = st_ff.tlp_valid;
  assign tlp_addr = st_ff.tlp_addr;
  assign tlp_data = st_ff.tlp_data;

  // ==================================================
  // checks
  a_held_pend: assert property (@(posedge ref_clk) disable iff (rst)
    app_msi_ack && app_msi_status == msp_pkg::ST_HELD |->
    st_ff.pend[$past(req_idx)]) else $error("held request left no pending bit");
  a_masked_silent: assert property (@(posedge ref_clk) disable iff (rst)
    app_msi_ack && app_msi_status == msp_pkg::ST_HELD |-> !$rose(tlp_valid))
    else $error("masked request started a message");
  a_sent_msg: assert property (@(posedge ref_clk) disable iff (rst)
    app_msi_ack && app_msi_status == msp_pkg::ST_SENT |->
    tlp_valid && tlp_addr == st_ff.addr) else $error("sent code without message");
  a_drop_off: assert property (@(posedge ref_clk) disable iff (rst)
    app_msi_ack && !$past(st_ff.msi_en) |-> app_msi_status == msp_pkg::ST_DROP)
    else $error("disabled request not dropped");
  a_release_send: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.msi_en && msi_cap_present && pick_found && !take && tlp_free |=> tlp_valid)
    else $error("pending unmasked vector not sent");
  a_release_clear: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.msi_en && msi_cap_present && pick_found && !take && tlp_free
    && !(app_msi_req && cfg_wr) |=> !st_ff.pend[$past(pick_idx)])
    else $error("delivered vector still pending");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_addr == msp_pkg::OFF_MASK |=>
    st_ff.mask[{$past(st_ff.fsel), 5'h00} +: 32] == $past(cfg_wdata))
    else $error("mask write not stored");
  a_intdis_write: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_addr == msp_pkg::OFF_CMD |=>
    st_ff.int_dis == $past(cfg_wdata[msp_pkg::CMD_INTDIS_BIT]))
    else $error("interrupt disable not stored");
  a_reset_clear: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> st_ff.pend == '0 && st_ff.mask == '0 && !st_ff.msi_en)
    else $error("reset left state behind");
  a_gate_off: assert property (@(posedge ref_clk) disable iff (rst)
    !st_ff.msi_en |=> !$rose(tlp_valid))
    else $error("message started while disabled");
endmodule : msp_top
`default_nettype wire

// *** rtl/msp_pkg.sv ***
// constants for the message interrupt mask and pending block
package msp_pkg;
  // ==================================================
  // sizes
  localparam int NUM_FUNC = 4;
  localparam int NUM_VEC = 32;
  localparam int NUM_BITS = NUM_FUNC * NUM_VEC;
  localparam int IDX_W = 7;
  // ==================================================
  // configuration offsets (byte addresses)
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h050;
  localparam logic [11:0] OFF_ADDR = 12'h054;
  localparam logic [11:0] OFF_DATA = 12'h058;
  localparam logic [11:0] OFF_MASK = 12'h05C;
  localparam logic [11:0] OFF_PEND = 12'h060;
  localparam logic [11:0] OFF_FSEL = 12'h064;
  // ==================================================
  // field positions
  localparam int CMD_INTDIS_BIT = 10;
  localparam int CTRL_EN_BIT = 16;
  localparam int CTRL_MMC_LSB = 17;
  localparam int CTRL_MME_LSB = 20;
  localparam int CTRL_PVM_BIT = 24;
  localparam logic [7:0] CAP_ID = 8'h05;
  localparam logic [2:0] MMC_VAL = 3'h5;
  localparam logic [2:0] MME_MAX = 3'h5;
  // ==================================================
  // request result codes
  localparam logic [1:0] ST_SENT = 2'h0;
  localparam logic [1:0] ST_HELD = 2'h1;
  localparam logic [1:0] ST_DROP = 2'h2;
endpackage : msp_pkg

// *** rtl/msp_pick.sv ***
// lowest index finder for releasable pending vectors
`timescale 1ns/1ps
`default_nettype none
module msp_pick (
  // candidates
  input wire logic [msp_pkg::NUM_BITS-1:0] cand,
  // result
  output logic found,
  output logic [msp_pkg::IDX_W-1:0] idx
);
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = msp_pkg::NUM_BITS - 1; i >= 0; i--) begin
      if (cand[i]) begin
        found = 1'b1;
        idx = msp_pkg::IDX_W'(i);
      end
    end
  end
endmodule : msp_pick
`default_nettype wire

// *** tb/msp_app_model.sv ***
// application side requester model for message interrupts
`timescale 1ns/1ps
`default_nettype none
module msp_app_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench command
  input wire logic start,
  input wire logic [1:0] func_in,
  input wire logic [4:0] num_in,
  output logic done,
  output logic [1:0] result,
  // request toward block
  output logic app_msi_req,
  output logic [1:0] app_msi_func,
  output logic [4:0] app_msi_num,
  input wire logic app_msi_ack,
  input wire logic [1:0] app_msi_status
);
  // ==========
  // request hold until ack
  always_ff @(posedge ref_clk) begin
    done <= 1'b0;
    if (rst) begin
      app_msi_req <= 1'b0;
      app_msi_func <= 2'h0;
      app_msi_num <= 5'h00;
    end else if (app_msi_req && app_msi_ack) begin
      app_msi_req <= 1'b0;
      app_msi_func <= ~app_msi_func;
      app_msi_num <= ~app_msi_num;
      result <= app_msi_status;
      done <= 1'b1;
    end else if (start && !app_msi_req) begin
      app_msi_req <= 1'b1;
      app_msi_func <= func_in;
      app_msi_num <= num_in;
    end
  end
endmodule : msp_app_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the message interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [1:0] f; logic [4:0] n; logic [1:0] st;} msp_row_s;
  localparam logic [1:0] SNT = msp_pkg::ST_SENT;
  localparam logic [1:0] HLD = msp_pkg::ST_HELD;
  localparam logic [1:0] DRP = msp_pkg::ST_DROP;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cap = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic start = 1'b0;
  logic tlp_ready = 1'b1;
  logic cfg_rd_valid, app_msi_req, app_msi_ack, done, tlp_valid;
  logic [11:0] cfg_addr = 12'h000;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata, tlp_addr, tlp_data, t_data, t_addr;
  logic [1:0] f_in = 2'h0;
  logic [4:0] n_in = 5'h00;
  logic [1:0] app_msi_func, app_msi_status, res;
  logic [4:0] app_msi_num;
  int mismatches = 0;
  int n_tests = 0;
  int n_tlp = 0;
  int c0;
  msp_row_s rows[7] = '{'{2'h0, 5'h00, SNT}, '{2'h1, 5'h00, SNT}, '{2'h1, 5'h01, HLD},
    '{2'h0, 5'h01, SNT}, '{2'h1, 5'h03, SNT}, '{2'h1, 5'h04, DRP}, '{2'h3, 5'h1F, DRP}};
  msp_top i_msp_top (.ref_clk(ref_clk), .rst(rst), .msi_cap_present(cap), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid), .app_msi_req(app_msi_req), .app_msi_func(app_msi_func),
    .app_msi_num(app_msi_num), .app_msi_ack(app_msi_ack), .app_msi_status(app_msi_status),
    .tlp_ready(tlp_ready), .tlp_valid(tlp_valid), .tlp_addr(tlp_addr), .tlp_data(tlp_data));
  msp_app_model i_msp_app_model (.ref_clk(ref_clk), .rst(rst), .start(start),
    .func_in(f_in), .num_in(n_in), .done(done), .result(res), .app_msi_req(app_msi_req),
    .app_msi_func(app_msi_func), .app_msi_num(app_msi_num), .app_msi_ack(app_msi_ack),
    .app_msi_status(app_msi_status));
  // ==========
  // clock and message monitor
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (tlp_valid === 1'b1 && tlp_ready === 1'b1) begin
      n_tlp <= n_tlp + 1;
      t_data <= tlp_data;
      t_addr <= tlp_addr;
    end
  end
  // ==========
  // tasks
  task conclude;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cw(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask : cw
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    chk("read valid", 32'h1, 32'(cfg_rd_valid));
    chk("read data", e, cfg_rdata);
  endtask : rd
  task ask(input logic [1:0] f, input logic [4:0] n);
    int k;
    @(posedge ref_clk);
    start <= 1'b1;
    f_in <= f;
    n_in <= n;
    @(posedge ref_clk);
    start <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 20) begin
      mismatches++;
      conclude();
    end
    @(posedge ref_clk);
    #1;
  endtask : ask
  // ==========
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(msp_pkg::OFF_CTRL, 32'h010A_0005);
    rd(msp_pkg::OFF_PEND, 32'h0000_0000);
    ask(2'h0, 5'h00);
    chk("status disabled", 32'(DRP), 32'(res));
    $display("test reset done");
    cw(msp_pkg::OFF_CMD, 32'h0000_0400);
    rd(msp_pkg::OFF_CMD, 32'h0000_0400);
    cw(msp_pkg::OFF_CTRL, 32'h0021_0000);
    rd(msp_pkg::OFF_CTRL, 32'h012B_0005);
    cw(msp_pkg::OFF_ADDR, 32'h0FEE_0000);
    cw(msp_pkg::OFF_DATA, 32'h0000_ABC0);
    cw(msp_pkg::OFF_FSEL, 32'h0000_0001);
    cw(msp_pkg::OFF_MASK, 32'h0000_0002);
    rd(msp_pkg::OFF_ADDR, 32'h0FEE_0000);
    rd(msp_pkg::OFF_DATA, 32'h0000_ABC0);
    rd(msp_pkg::OFF_MASK, 32'h0000_0002);
    foreach (rows[i]) begin
      c0 = n_tlp;
      ask(rows[i].f, rows[i].n);
      chk("status", 32'(rows[i].st), 32'(res));
      chk("msg count", 32'(c0 + (rows[i].st == SNT)), 32'(n_tlp));
      if (rows[i].st == SNT) begin
        chk("msg data", 32'h0000_ABC0 | 32'(rows[i].n[1:0]), t_data);
      end
    end
    chk("msg addr", 32'h0FEE_0000, t_addr);
    rd(msp_pkg::OFF_PEND, 32'h0000_0002);
    $display("test rows done");
    c0 = n_tlp;
    @(posedge ref_clk);
    tlp_ready <= 1'b0;
    cw(msp_pkg::OFF_MASK, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("msg waiting", 32'h1, 32'(tlp_valid));
    @(posedge ref_clk);
    tlp_ready <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("released count", 32'(c0 + 1), 32'(n_tlp));
    chk("released data", 32'h0000_ABC1, t_data);
    rd(msp_pkg::OFF_PEND, 32'h0000_0000);
    $display("test release done");
    cw(msp_pkg::OFF_MASK, 32'h0000_0002);
    ask(2'h1, 5'h01);
    chk("status masked", 32'(HLD), 32'(res));
    cw(msp_pkg::OFF_PEND, 32'h0000_0002);
    c0 = n_tlp;
    cw(msp_pkg::OFF_MASK, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("cleared count", 32'(c0), 32'(n_tlp));
    rd(msp_pkg::OFF_PEND, 32'h0000_0000);
    $display("test drop done");
    @(posedge ref_clk);
    cap <= 1'b0;
    ask(2'h0, 5'h00);
    chk("status absent", 32'(DRP), 32'(res));
    @(posedge ref_clk);
    cap <= 1'b1;
    cw(msp_pkg::OFF_FSEL, 32'h0000_0000);
    cw(msp_pkg::OFF_MASK, 32'h0000_0004);
    ask(2'h0, 5'h02);
    chk("status before reset", 32'(HLD), 32'(res));
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(msp_pkg::OFF_CTRL, 32'h010A_0005);
    rd(msp_pkg::OFF_MASK, 32'h0000_0000);
    rd(msp_pkg::OFF_PEND, 32'h0000_0000);
    $display("test second reset done");
    cw(msp_pkg::OFF_CTRL, 32'h0071_0000);
    rd(msp_pkg::OFF_CTRL, 32'h015B_0005);
    cw(msp_pkg::OFF_MASK, 32'h0000_0001);
    ask(2'h0, 5'h00);
    chk("status gated", 32'(HLD), 32'(res));
    cw(msp_pkg::OFF_CTRL, 32'h0000_0000);
    c0 = n_tlp;
    cw(msp_pkg::OFF_MASK, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("gated count", 32'(c0), 32'(n_tlp));
    rd(msp_pkg::OFF_PEND, 32'h0000_0001);
    cw(msp_pkg::OFF_CTRL, 32'h0001_0000);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("enabled count", 32'(c0 + 1), 32'(n_tlp));
    rd(msp_pkg::OFF_PEND, 32'h0000_0000);
    $display("test enable gate done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
